// *** rtl/piet_chan_mem.sv ***
// Small memory holding the pointers and counters of the transfer channels.
`timescale 1ns/1ps
module piet_chan_mem (
    input  wire logic                       clk_i,
    input  wire logic                       we_i,
    input  wire logic [piet_pkg::CHAN_W-1:0] waddr_i,
    input  wire piet_pkg::piet_chan_cfg_type wdata_i,
    input  wire logic [piet_pkg::CHAN_W-1:0] raddr_i,
    output piet_pkg::piet_chan_cfg_type      rdata_o
);
    piet_pkg::piet_chan_cfg_type mem [piet_pkg::NUM_CHAN];

    // Writes and a registered read port.
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

// *** rtl/piet_pkg.sv ***
// Package with constants and carrier types of the interrupt and event transfer controller.
package piet_pkg;
    localparam int NUM_SRC      = 30;
    localparam int SRC_W        = 5;
    localparam int NUM_CHAN     = 8;
    localparam int CHAN_W       = 3;
    localparam int NUM_FAST     = 4;
    localparam int PRIO_W       = 4;
    localparam int TRAP_W       = 7;
    localparam int ADDR_W       = 24;
    localparam int DATA_W       = 16;
    localparam int CNT_W        = 8;
    localparam int VEC_SHIFT    = 2;
    localparam logic [TRAP_W-1:0] FAST_TRAP_BASE = 7'h18;
    localparam logic [TRAP_W-1:0] SRC_TRAP [NUM_SRC] = '{
        7'h18, 7'h19, 7'h1A, 7'h1B, 7'h22, 7'h23, 7'h24, 7'h28, 7'h29, 7'h2A,
        7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F, 7'h30, 7'h31, 7'h32, 7'h33, 7'h38,
        7'h39, 7'h3A, 7'h3B, 7'h3D, 7'h3E, 7'h3F, 7'h40, 7'h43, 7'h47, 7'h4D};
    localparam int CLK_MHZ      = 250;
    localparam int RESP_MIN_NS  = 250;
    localparam int RESP_MAX_NS  = 600;
    localparam int RESP_MIN_CYC = (RESP_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int RESP_MAX_CYC = (RESP_MAX_NS * CLK_MHZ) / 1000;
    localparam int RESP_CNT_W   = 8;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    typedef struct packed {
        logic              enable;
        logic              use_chan;
        logic [CHAN_W-1:0] chan;
        logic [PRIO_W-1:0] prio;
    } piet_src_cfg_type;

    typedef struct packed {
        logic              word_mode;
        logic              inc_dst;
        logic              continuous;
        logic [ADDR_W-1:0] src_ptr;
        logic [ADDR_W-1:0] dst_ptr;
        logic [CNT_W-1:0]  count;
    } piet_chan_cfg_type;

    typedef struct packed {
        logic              valid;
        logic [TRAP_W-1:0] trap;
        logic [ADDR_W-1:0] vector;
        logic [PRIO_W-1:0] prio;
    } piet_irq_type;

    typedef struct packed {
        logic              valid;
        logic              word_mode;
        logic [ADDR_W-1:0] src_addr;
        logic [ADDR_W-1:0] dst_addr;
    } piet_xfer_type;
endpackage

// *** rtl/piet_top.sv ***
// Prioritized interrupt controller with an eight channel event transfer engine.
`timescale 1ns/1ps
// Function
// R1 - Every source has a request flag, an enable flag and a four bit priority of sixteen levels.
// R2 - An accepted service is preempted only by a pending request of strictly higher priority.
// R3 - A standard interrupt branches to its own vector, which is its trap number times four.
// R4 - Every source is set up either as a vectored interrupt or as a channel transfer.
// R5 - A channel transfer takes exactly one CPU cycle and does not branch.
// R6 - A transfer moves a byte or word and then bumps the source or destination pointer.
// R7 - The counter drops by one per transfer except in continuous mode.
// R8 - When a channel counter reaches zero the source's own vectored interrupt is raised.
// R9 - There are eight independent transfer channels.
// R10 - Fast external inputs detect rising, falling or both edges as programmed.
// R11 - A software trap branches to the vector of its trap number like a hardware interrupt.
// R12 - Response from request to service start lies between 250 ns and 600 ns.
// R13 - The fast external sources use trap numbers 18H to 1BH and vectors from 60H up.
// R14 - While a hardware trap service runs, interrupts and transfers are blocked.
// R15 - A request is arbitrated only while enabled and is cleared when serviced.
// R16 - The highest priority enabled pending request is presented to the CPU.
module piet_top (
    input  wire logic                                       clk_i,
    input  wire logic                                       nrst_i,
    input  wire logic [piet_pkg::NUM_SRC-1:piet_pkg::NUM_FAST] periph_req_i,
    input  wire logic [piet_pkg::NUM_FAST-1:0]              fast_ext_pin_i,
    input  wire logic [piet_pkg::NUM_FAST-1:0][1:0]         fast_edge_sel_i,
    input  wire piet_pkg::piet_src_cfg_type [piet_pkg::NUM_SRC-1:0] src_cfg_i,
    input  wire logic [piet_pkg::NUM_SRC-1:0]               flag_set_i,
    input  wire logic [piet_pkg::NUM_SRC-1:0]               flag_clr_i,
    input  wire logic                                       chan_we_i,
    input  wire logic [piet_pkg::CHAN_W-1:0]                chan_waddr_i,
    input  wire piet_pkg::piet_chan_cfg_type                chan_wdata_i,
    input  wire logic [piet_pkg::PRIO_W-1:0]                cpu_prio_i,
    input  wire logic                                       hw_trap_active_i,
    input  wire logic                                       sw_trap_i,
    input  wire logic [piet_pkg::TRAP_W-1:0]                sw_trap_num_i,
    input  wire logic                                       irq_ack_i,
    input  wire logic                                       xfer_done_i,
    output piet_pkg::piet_irq_type                          irq_o,
    output piet_pkg::piet_irq_type                          sw_branch_o,
    output piet_pkg::piet_xfer_type                         xfer_o,
    output logic                                            cpu_stall_o,
    output logic [piet_pkg::NUM_SRC-1:0]                    req_flag_o
);
    typedef enum logic [1:0] {IDLE, READ, MOVE, WRITE} piet_xs_type;

    logic                                    rst_s1;
    logic                                    rst_n;
    logic [piet_pkg::NUM_FAST-1:0]           pin_s1;
    logic [piet_pkg::NUM_FAST-1:0]           pin_s2;
    logic [piet_pkg::NUM_FAST-1:0]           pin_old;
    logic [piet_pkg::NUM_FAST-1:0]           fast_evt;
    logic [piet_pkg::NUM_SRC-1:0]            raw_evt;
    logic [piet_pkg::NUM_SRC-1:0]            term_evt;
    logic [piet_pkg::NUM_SRC-1:0]            term_flag;
    logic [piet_pkg::NUM_SRC-1:0]            next_flag;
    logic [piet_pkg::NUM_SRC-1:0]            svc_clr;
    logic                                    win_valid;
    logic [piet_pkg::SRC_W-1:0]              win_src;
    logic [piet_pkg::PRIO_W-1:0]             win_prio;
    logic                                    win_chan;
    piet_xs_type                             xstate;
    logic [piet_pkg::SRC_W-1:0]              xsrc;
    logic [piet_pkg::CHAN_W-1:0]             xchan;
    logic [piet_pkg::CHAN_W-1:0]             rd_chan;
    piet_pkg::piet_chan_cfg_type             chan_rd;
    piet_pkg::piet_chan_cfg_type             chan_upd;
    logic                                    upd_we;
    logic                                    mem_we;
    logic [piet_pkg::CHAN_W-1:0]             mem_waddr;
    piet_pkg::piet_chan_cfg_type             mem_wdata;
    logic [piet_pkg::RESP_CNT_W-1:0]         wait_cnt;
    logic                                    resp_ok;

    function automatic logic [piet_pkg::ADDR_W-1:0] vec_of(
        input logic [piet_pkg::TRAP_W-1:0] trap);
        vec_of = piet_pkg::ADDR_W'({trap, piet_pkg::VEC_SHIFT'(0)}); // [R3] [R11] [R13]
    endfunction

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // Pin synchroniser and edge detection of the fast external inputs.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1  <= '0;
            pin_s2  <= '0;
            pin_old <= '0;
        end else begin
            pin_s1  <= fast_ext_pin_i;
            pin_s2  <= pin_s1;
            pin_old <= pin_s2;
        end
    end

    genvar g;
    generate
        for (g = 0; g < piet_pkg::NUM_FAST; g++) begin : g_fast
            assign fast_evt[g] =
                ((fast_edge_sel_i[g] == piet_pkg::EDGE_RISE || fast_edge_sel_i[g] ==
                  piet_pkg::EDGE_BOTH) && pin_s2[g] && !pin_old[g]) ||
                ((fast_edge_sel_i[g] == piet_pkg::EDGE_FALL || fast_edge_sel_i[g] ==
                  piet_pkg::EDGE_BOTH) && !pin_s2[g] && pin_old[g]); // [R10]
        end
    endgenerate

    assign raw_evt = {periph_req_i, fast_evt};

    // Request flags: an event or a set wins over any clear.
    always_comb begin
        next_flag = (req_flag_o & ~flag_clr_i & ~svc_clr) | raw_evt | flag_set_i
                    | term_evt; // [R1] [R15] [R8]
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            req_flag_o <= '0;
        end else begin
            req_flag_o <= next_flag;
        end
    end

    // Marks sources whose channel has run out, so they go to their vector instead.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            term_flag <= '0;
        end else begin
            term_flag <= (term_flag & ~(svc_clr & ~{piet_pkg::NUM_SRC{win_chan}}))
                         | term_evt; // [R8]
        end
    end

    // Priority arbitration over enabled pending flags; lower index wins on a tie.
    always_comb begin
        win_valid = 1'b0;
        win_src   = '0;
        win_prio  = '0;
        for (int i = 0; i < piet_pkg::NUM_SRC; i++) begin
            if (req_flag_o[i] && src_cfg_i[i].enable &&
                (!win_valid || src_cfg_i[i].prio > win_prio)) begin // [R15] [R16]
                win_valid = 1'b1;
                win_src   = piet_pkg::SRC_W'(i);
                win_prio  = src_cfg_i[i].prio;
            end
        end
        win_chan = src_cfg_i[win_src].use_chan && !term_flag[win_src]; // [R4]
    end

    // Response timer: a request waits the least time, and the count holds once it reaches the longest.
    assign resp_ok = wait_cnt >= piet_pkg::RESP_CNT_W'(piet_pkg::RESP_MIN_CYC - 2);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= '0;
        end else if (!win_valid || irq_ack_i || xstate != IDLE) begin
            wait_cnt <= '0;
        end else if (wait_cnt < piet_pkg::RESP_CNT_W'(piet_pkg::RESP_MAX_CYC)) begin
            wait_cnt <= wait_cnt + 1'b1; // [R12]
        end
    end

    // Vectored request to the CPU, gated by priority and hardware trap activity.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_o <= '0;
        end else begin
            irq_o.valid  <= win_valid && !win_chan && resp_ok && !irq_ack_i &&
                            !hw_trap_active_i && win_prio > cpu_prio_i; // [R2] [R14] [R12]
            irq_o.trap   <= piet_pkg::SRC_TRAP[win_src];
            irq_o.vector <= vec_of(piet_pkg::SRC_TRAP[win_src]); // [R3] [R13]
            irq_o.prio   <= win_prio;
        end
    end

    // Software traps branch at once to the vector of their number.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sw_branch_o <= '0;
        end else begin
            sw_branch_o.valid  <= sw_trap_i;
            sw_branch_o.trap   <= sw_trap_num_i;
            sw_branch_o.vector <= vec_of(sw_trap_num_i); // [R11]
            sw_branch_o.prio   <= cpu_prio_i;
        end
    end

    // Clears the flag of the source being serviced.
    always_comb begin
        svc_clr = '0;
        if (irq_o.valid && irq_ack_i) begin
            for (int i = 0; i < piet_pkg::NUM_SRC; i++) begin
                if (piet_pkg::SRC_TRAP[i] == irq_o.trap) begin
                    svc_clr[i] = 1'b1; // [R15]
                end
            end
        end else if (xstate == IDLE && win_valid && win_chan && resp_ok &&
                     !hw_trap_active_i && win_prio > cpu_prio_i) begin
            svc_clr[win_src] = 1'b1; // [R15] [R14] [R2]
        end
    end

    // Transfer engine: fetch channel, steal one CPU cycle, write back the channel.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            xstate <= IDLE;
            xsrc   <= '0;
            xchan  <= '0;
        end else begin
            unique case (xstate)
                IDLE: begin
                    if (|svc_clr && !(irq_o.valid && irq_ack_i)) begin
                        xstate <= READ;
                        xsrc   <= win_src;
                        xchan  <= src_cfg_i[win_src].chan; // [R9]
                    end
                end
                READ: begin
                    xstate <= MOVE;
                end
                MOVE: begin
                    if (xfer_done_i) begin
                        xstate <= WRITE; // [R5]
                    end
                end
                WRITE: begin
                    xstate <= IDLE;
                end
            endcase
        end
    end

    assign cpu_stall_o = xstate == MOVE; // [R5]

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            xfer_o <= '0;
        end else begin
            xfer_o.valid     <= xstate == READ; // [R5]
            xfer_o.word_mode <= chan_rd.word_mode;
            xfer_o.src_addr  <= chan_rd.src_ptr;
            xfer_o.dst_addr  <= chan_rd.dst_ptr; // [R6]
        end
    end

    // Pointer and counter update after the move.
    always_comb begin
        chan_upd = chan_rd;
        if (chan_rd.inc_dst) begin
            chan_upd.dst_ptr = chan_rd.dst_ptr + (chan_rd.word_mode ? 24'h000002 : 24'h000001);
        end else begin
            chan_upd.src_ptr = chan_rd.src_ptr + (chan_rd.word_mode ? 24'h000002 : 24'h000001);
        end // [R6]
        if (!chan_rd.continuous && chan_rd.count != '0) begin
            chan_upd.count = chan_rd.count - 1'b1; // [R7]
        end
        upd_we   = xstate == WRITE;
        term_evt = '0;
        if (upd_we && !chan_rd.continuous && chan_upd.count == '0) begin
            term_evt[xsrc] = 1'b1; // [R8]
        end
    end

    // While idle the read port follows the winner, so its channel is ready in READ.
    assign rd_chan = (xstate == IDLE) ? src_cfg_i[win_src].chan : xchan; // [R9]

    assign mem_we    = upd_we || chan_we_i;
    assign mem_waddr = upd_we ? xchan : chan_waddr_i;
    assign mem_wdata = upd_we ? chan_upd : chan_wdata_i;

    piet_chan_mem u_chan_mem (
        .clk_i   (clk_i),
        .we_i    (mem_we),
        .waddr_i (mem_waddr),
        .wdata_i (mem_wdata),
        .raddr_i (rd_chan),
        .rdata_o (chan_rd)
    );
endmodule

// *** testbench/piet_checker.sv ***
// Concurrent checks on the ports of the interrupt and transfer controller.
`timescale 1ns/1ps
module piet_checker (
    input wire logic                        clk_i,
    input wire logic                        nrst_i,
    input wire logic [piet_pkg::PRIO_W-1:0] cpu_prio_i,
    input wire logic                        hw_trap_active_i,
    input wire logic                        sw_trap_i,
    input wire logic [piet_pkg::TRAP_W-1:0] sw_trap_num_i,
    input wire logic                        irq_ack_i,
    input wire logic                        xfer_done_i,
    input wire piet_pkg::piet_irq_type      irq_o,
    input wire piet_pkg::piet_irq_type      sw_branch_o,
    input wire piet_pkg::piet_xfer_type     xfer_o,
    input wire logic                        cpu_stall_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sw_vector_a: assert property (sw_trap_i |=> sw_branch_o.valid &&
        sw_branch_o.vector == {15'h0, $past(sw_trap_num_i), 2'h0}) else $error("sw vector wrong");
    irq_vector_a: assert property (irq_o.valid |->
        irq_o.vector == {15'h0, irq_o.trap, 2'h0}) else $error("irq vector wrong");
    irq_prio_a: assert property ($rose(irq_o.valid) |->
        irq_o.prio > $past(cpu_prio_i)) else $error("irq not above cpu priority");
    hw_block_a: assert property ($rose(irq_o.valid) |->
        !$past(hw_trap_active_i)) else $error("irq during hw trap");
    irq_hold_a: assert property (irq_o.valid && !irq_ack_i |=>
        irq_o.valid && $stable(irq_o.trap)) else $error("irq dropped before ack");
    ack_drop_a: assert property (irq_o.valid && irq_ack_i |=>
        !irq_o.valid [*3]) else $error("irq stays after ack");
    xfer_pulse_a: assert property (xfer_o.valid |->
        cpu_stall_o ##1 !xfer_o.valid) else $error("transfer pulse wrong");
    stall_end_a: assert property (cpu_stall_o && xfer_done_i |=>
        !cpu_stall_o) else $error("stall outlives done");
    stall_cause_a: assert property ($rose(cpu_stall_o) |->
        xfer_o.valid) else $error("stall without transfer");
endmodule

// *** testbench/piet_cpu_model.sv ***
// Behavioural CPU that accepts interrupts and ends stolen transfer cycles.
`timescale 1ns/1ps
module piet_cpu_model (
    input  wire logic                   clk_i,
    input  wire logic                   slow_i,
    input  wire piet_pkg::piet_irq_type irq_i,
    input  wire logic                   stall_i,
    output logic                        ack_o,
    output logic                        done_o
);
    int ack_wait = 0;
    int done_wait = 0;
    initial ack_o = 1'b0;
    initial done_o = 1'b0;
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        done_o <= 1'b0;
        // Accepts a presented request after a short or a long decode delay.
        if (irq_i.valid && !ack_o) begin
            ack_wait <= ack_wait + 1;
            if (ack_wait >= (slow_i ? 6 : 1)) begin
                ack_o <= 1'b1;
                ack_wait <= 0;
            end
        end
        // Ends the stolen bus cycle with no or several wait states.
        if (stall_i && !done_o) begin
            done_wait <= done_wait + 1;
            if (done_wait >= (slow_i ? 5 : 0)) begin
                done_o <= 1'b1;
                done_wait <= 0;
            end
        end
    end
endmodule

// *** testbench/piet_top_bench.sv ***
// Self-checking bench of the interrupt and event transfer controller.
`timescale 1ns/1ps
module piet_top_bench;
    localparam int NS = piet_pkg::NUM_SRC;
    localparam int NF = piet_pkg::NUM_FAST;
    logic                             clk_i = 1'b0;
    logic                             nrst_i = 1'b0;
    logic [NS-1:NF]                   periph_req_i = '0;
    logic [NF-1:0]                    fast_ext_pin_i = '0;
    logic [NF-1:0][1:0]               fast_edge_sel_i = '0;
    piet_pkg::piet_src_cfg_type [NS-1:0] src_cfg_i = '0;
    logic [NS-1:0]                    flag_set_i = '0;
    logic [NS-1:0]                    flag_clr_i = '0;
    logic                             chan_we_i = 1'b0;
    logic [2:0]                       chan_waddr_i = '0;
    piet_pkg::piet_chan_cfg_type      chan_wdata_i = '0;
    logic [3:0]                       cpu_prio_i = '0;
    logic                             hw_trap_active_i = 1'b0;
    logic                             sw_trap_i = 1'b0;
    logic [6:0]                       sw_trap_num_i = '0;
    logic                             slow = 1'b0;
    logic                             irq_ack_i;
    logic                             xfer_done_i;
    logic                             cpu_stall_o;
    piet_pkg::piet_irq_type           irq_o;
    piet_pkg::piet_irq_type           sw_branch_o;
    piet_pkg::piet_xfer_type          xfer_o;
    logic [NS-1:0]                    req_flag_o;
    logic [6:0]                       sw_nums [3] = '{7'h00, 7'h2A, 7'h7F};
    int                               err_total = 0;
    int                               comparisons = 0;
    int                               cyc = 0;
    int                               lat;
    piet_top u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .periph_req_i(periph_req_i),
        .fast_ext_pin_i(fast_ext_pin_i), .fast_edge_sel_i(fast_edge_sel_i),
        .src_cfg_i(src_cfg_i), .flag_set_i(flag_set_i), .flag_clr_i(flag_clr_i),
        .chan_we_i(chan_we_i), .chan_waddr_i(chan_waddr_i), .chan_wdata_i(chan_wdata_i),
        .cpu_prio_i(cpu_prio_i), .hw_trap_active_i(hw_trap_active_i), .sw_trap_i(sw_trap_i),
        .sw_trap_num_i(sw_trap_num_i), .irq_ack_i(irq_ack_i), .xfer_done_i(xfer_done_i),
        .irq_o(irq_o), .sw_branch_o(sw_branch_o), .xfer_o(xfer_o),
        .cpu_stall_o(cpu_stall_o), .req_flag_o(req_flag_o));
    piet_cpu_model u_cpu (.clk_i(clk_i), .slow_i(slow), .irq_i(irq_o),
        .stall_i(cpu_stall_o), .ack_o(irq_ack_i), .done_o(xfer_done_i));
    always #2 clk_i = ~clk_i;
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic look(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic raise(logic [NS-1:NF] m);
        tick(1);
        periph_req_i <= m;
        tick(1);
        periph_req_i <= '0;
    endtask
    task automatic clear_flags();
        tick(1);
        flag_clr_i <= '1;
        tick(1);
        flag_clr_i <= '0;
    endtask
    task automatic wait_irq(logic [6:0] trap);
        lat = 0;
        while (irq_o.valid !== 1'b1 && lat < 400) begin
            look(1);
            lat++;
        end
        check("irq valid", 32'h1, {31'h0, irq_o.valid});
        check("irq trap", {25'h0, trap}, {25'h0, irq_o.trap});
        check("irq vector", {15'h0, trap, 2'h0, 8'h0}, {irq_o.vector, 8'h0});
        look(12);
    endtask
    task automatic wait_xfer(logic word, logic [23:0] src, logic [23:0] dst);
        lat = 0;
        while (xfer_o.valid !== 1'b1 && lat < 400) begin
            look(1);
            lat++;
        end
        check("xfer valid", 32'h1, {31'h0, xfer_o.valid});
        check("xfer src", {7'h0, word, src}, {7'h0, xfer_o.word_mode, xfer_o.src_addr});
        check("xfer dst", {8'h0, dst}, {8'h0, xfer_o.dst_addr});
        look(12);
    endtask
    task automatic summarize();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        tick(20);
        nrst_i <= 1'b1;
        tick(5);
        for (int m = 0; m < 4; m++) begin
            fast_edge_sel_i <= {4{m[1:0]}};
            fast_ext_pin_i <= '1;
            look(8);
            check("rise flags", {28'h0, {4{m[0]}}}, {28'h0, req_flag_o[3:0]});
            clear_flags();
            fast_ext_pin_i <= '0;
            look(8);
            check("fall flags", {28'h0, {4{m[1]}}}, {28'h0, req_flag_o[3:0]});
            clear_flags();
        end
        flag_set_i <= '1;
        flag_clr_i <= '1;
        tick(1);
        flag_set_i <= '0;
        flag_clr_i <= '0;
        look(1);
        check("set flags", 32'h3FFFFFFF, {2'h0, req_flag_o});
        clear_flags();
        fast_edge_sel_i <= {4{piet_pkg::EDGE_RISE}};
        for (int k = 0; k < NF; k++) begin
            src_cfg_i[k] <= {2'h2, 3'h0, 4'h5};
            fast_ext_pin_i[k] <= 1'b1;
            wait_irq(7'h18 + 7'(k));
            check("response", 32'h1, {31'h0, lat >= piet_pkg::RESP_MIN_CYC &&
                lat <= piet_pkg::RESP_MAX_CYC});
            check("flag cleared", 32'h0, {31'h0, req_flag_o[k]});
            tick(1);
            src_cfg_i[k] <= '0;
        end
        cpu_prio_i <= 4'h3;
        src_cfg_i[4] <= {2'h2, 3'h0, 4'h3};
        src_cfg_i[10] <= {2'h2, 3'h0, 4'h9};
        raise(26'h41);
        wait_irq(piet_pkg::SRC_TRAP[10]);
        look(200);
        check("equal prio held", 32'h1, {31'h0, req_flag_o[4] && !irq_o.valid});
        tick(1);
        cpu_prio_i <= 4'h2;
        wait_irq(piet_pkg::SRC_TRAP[4]);
        tick(1);
        hw_trap_active_i <= 1'b1;
        src_cfg_i[5] <= {2'h2, 3'h0, 4'hF};
        raise(26'h2);
        look(150);
        check("hw trap held", 32'h1, {31'h0, req_flag_o[5] && !irq_o.valid});
        tick(1);
        hw_trap_active_i <= 1'b0;
        wait_irq(piet_pkg::SRC_TRAP[5]);
        for (int t = 0; t < 3; t++) begin
            tick(1);
            sw_trap_i <= 1'b1;
            sw_trap_num_i <= sw_nums[t];
            look(1);
            check("sw branch", {8'h1, 15'h0, sw_nums[t], 2'h0},
                {7'h0, sw_branch_o.valid, sw_branch_o.vector});
            check("sw trap", {25'h0, sw_nums[t]}, {25'h0, sw_branch_o.trap});
            check("sw prio", 32'h2, {28'h0, sw_branch_o.prio});
            tick(1);
            sw_trap_i <= 1'b0;
        end
        chan_we_i <= 1'b1;
        chan_waddr_i <= 3'h2;
        chan_wdata_i <= {3'b110, 24'h000100, 24'h000200, 8'h02};
        src_cfg_i[6] <= {2'h3, 3'h2, 4'h4};
        tick(1);
        chan_we_i <= 1'b0;
        raise(26'h4);
        wait_xfer(1'b1, 24'h000100, 24'h000200);
        check("no branch", 32'h0, {31'h0, req_flag_o[6] | irq_o.valid});
        raise(26'h4);
        wait_xfer(1'b1, 24'h000100, 24'h000202);
        wait_irq(piet_pkg::SRC_TRAP[6]);
        tick(1);
        slow <= 1'b1;
        chan_we_i <= 1'b1;
        chan_waddr_i <= 3'h7;
        chan_wdata_i <= {3'b001, 24'h000010, 24'h000080, 8'h01};
        src_cfg_i[7] <= {2'h3, 3'h7, 4'h6};
        tick(1);
        chan_we_i <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            raise(26'h8);
            wait_xfer(1'b0, 24'h000010 + 24'(i), 24'h000080);
        end
        look(100);
        check("continuous", 32'h0, {31'h0, req_flag_o[7] | irq_o.valid});
        summarize();
    end
endmodule
bind piet_top piet_checker u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .cpu_prio_i(cpu_prio_i),
    .hw_trap_active_i(hw_trap_active_i), .sw_trap_i(sw_trap_i), .sw_trap_num_i(sw_trap_num_i),
    .irq_ack_i(irq_ack_i), .xfer_done_i(xfer_done_i), .irq_o(irq_o),
    .sw_branch_o(sw_branch_o), .xfer_o(xfer_o), .cpu_stall_o(cpu_stall_o));
